// *** logic/uss_uart.sv ***
// Serial transceiver with status flags, stop-bit modes and break
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module uss_uart #(
    parameter int RX_DEPTH = 8,
    parameter logic [15:0] BAUD_DIV = uss_pkg::BAUD_RST
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Register port
    input wire logic [uss_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Serial line
    input wire logic rx_pin,
    output logic tx_pin,
    // Interrupt
    output logic irq
);
    import uss_pkg::*;

    localparam int PW = $clog2(RX_DEPTH);
    localparam logic [PW:0] DEPTH_CNT = (PW+1)'(RX_DEPTH);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic rx_en;
        logic tx_en;
        logic [1:0] ssel;
        logic brk;
        logic [15:0] baud;
        logic [IRQ_W-1:0] mask;
        logic [IRQ_W-1:0] ist;
        logic ovr;
        logic framing_error_flag;
        logic twe;
        logic [7:0] tbuf;
        logic tbuf_full;
        uss_tx_type tx_st;
        logic [15:0] tx_cnt;
        logic [3:0] tx_bit;
        logic [7:0] tx_sh;
        logic tx_line;
        logic rx_s1;
        logic rx_s2;
        uss_rx_type rx_st;
        logic [15:0] rx_cnt;
        logic [2:0] rx_bit;
        logic [7:0] rx_sh;
        logic [RX_DEPTH-1:0][7:0] fifo;
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [PW:0] cnt;
        logic [31:0] rdata;
        logic irq;
    } uss_state_type;

    // Idle line and sync stages reset high so no false start appears
    localparam uss_state_type ST_RST = '{
        tx_st: TX_IDLE, rx_st: RX_IDLE, baud: BAUD_DIV,
        tx_line: 1'b1, rx_s1: 1'b1, rx_s2: 1'b1, default: '0};

    uss_state_type r;
    uss_state_type s;
    logic tx_tick, rx_tick, rx_half;
    logic push, pop, ovr_ev, framing_error_flag_ev, twe_ev, txd_ev, brk_done;
    logic twe_clr, ovr_clr, framing_error_flag_clr;
    logic [31:0] sv;

    // Bit timers: one bit lasts baud+1 clocks
    assign tx_tick = (r.tx_cnt == r.baud);
    assign rx_tick = (r.rx_cnt == r.baud);
    assign rx_half = (r.rx_cnt == {1'b0, r.baud[15:1]});

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        s = r;
        push = 1'b0;
        ovr_ev = 1'b0;
        framing_error_flag_ev = 1'b0;
        twe_ev = 1'b0;
        txd_ev = 1'b0;
        brk_done = 1'b0;
        twe_clr = 1'b0;
        ovr_clr = reg_wr && reg_addr == STAT_OFS && !reg_wdata[S_OVR];
        framing_error_flag_clr = reg_wr && reg_addr == STAT_OFS && !reg_wdata[S_FRAMING_ERROR_FLAG];
        pop = reg_rd && reg_addr == RXD_OFS && r.cnt != '0;
        // Only the second stage is read by logic
        s.rx_s1 = rx_pin;
        s.rx_s2 = r.rx_s1;

        // Register writes
        if (reg_wr) begin
            case (reg_addr)
                MODE_OFS: begin
                    s.rx_en = reg_wdata[M_RXEN];
                    s.tx_en = reg_wdata[M_TXEN];
                    s.ssel = reg_wdata[M_SSEL +: 2];
                    s.brk = reg_wdata[M_BRK];
                    twe_clr = !reg_wdata[M_TXEN];
                end
                TXD_OFS: begin
                    if (r.tbuf_full || !r.tx_en) begin
                        twe_ev = 1'b1;
                    end else begin
                        s.tbuf = reg_wdata[7:0];
                        s.tbuf_full = 1'b1;
                    end
                end
                BAUD_OFS: s.baud = reg_wdata[15:0];
                IMSK_OFS: s.mask = reg_wdata[IRQ_W-1:0];
                default: ;
            endcase
        end

        // Status word, read back and used by the read mux
        sv = '0;
        sv[S_RXRDY] = r.cnt != '0;
        sv[S_OVR] = r.ovr;
        sv[S_FRAMING_ERROR_FLAG] = r.framing_error_flag;
        // shifter empty once nothing queued or shifting
        sv[S_TX_SHIFTER_EMPTY] = r.tx_st == TX_IDLE && !r.tbuf_full;
        // buffer empty tells software it may write
        sv[S_TBE] = !r.tbuf_full;
        sv[S_TWE] = r.twe;

        // Read data, valid only in the cycle after the strobe
        s.rdata = '0;
        if (reg_rd) begin
            case (reg_addr)
                MODE_OFS: begin
                    s.rdata[M_RXEN] = r.rx_en;
                    s.rdata[M_TXEN] = r.tx_en;
                    s.rdata[M_SSEL +: 2] = r.ssel;
                    s.rdata[M_BRK] = r.brk;
                end
                STAT_OFS: s.rdata = sv;
                RXD_OFS: s.rdata[7:0] = r.fifo[r.rp];
                BAUD_OFS: s.rdata[15:0] = r.baud;
                IST_OFS: s.rdata[IRQ_W-1:0] = r.ist;
                IMSK_OFS: s.rdata[IRQ_W-1:0] = r.mask;
                default: ;
            endcase
        end

        // Transmitter
        s.tx_cnt = (r.tx_st == TX_IDLE || tx_tick) ? '0 : r.tx_cnt + 16'h0001;
        case (r.tx_st)
            TX_IDLE: begin
                if (r.tx_en && r.brk) begin
                    s.tx_st = TX_BRK;
                    s.tx_bit = '0;
                    s.tx_line = 1'b0;
                end else if (r.tx_en && r.tbuf_full) begin
                    s.tx_st = TX_START;
                    s.tx_sh = r.tbuf;
                    s.tbuf_full = 1'b0;
                    s.tx_line = 1'b0;
                end
            end
            TX_START: begin
                if (tx_tick) begin
                    s.tx_st = TX_DATA;
                    s.tx_bit = '0;
                    s.tx_line = r.tx_sh[0];
                end
            end
            TX_DATA: begin
                if (tx_tick) begin
                    s.tx_sh = {1'b0, r.tx_sh[7:1]};
                    s.tx_bit = r.tx_bit + 4'h1;
                    s.tx_line = r.tx_sh[1];
                    if (r.tx_bit[2:0] == LAST_BIT) begin
                        s.tx_st = TX_STOP1;
                        s.tx_line = 1'b1;
                    end
                end
            end
            TX_STOP1: begin
                if (tx_tick) begin
                    // select 2 sends a second stop bit
                    // select 3 sends one as well
                    if (r.ssel == SSEL_TWO_CHK || r.ssel == SSEL_ONE_CHK) begin
                        s.tx_st = TX_STOP2;
                    end else begin
                        s.tx_st = TX_IDLE;
                        txd_ev = 1'b1;
                    end
                end
            end
            TX_STOP2: begin
                if (tx_tick) begin
                    s.tx_st = TX_IDLE;
                    txd_ev = 1'b1;
                end
            end
            TX_BRK: begin
                // Line held low for a whole break, then a stop bit
                if (tx_tick) begin
                    s.tx_bit = r.tx_bit + 4'h1;
                    if (r.tx_bit == BRK_LAST) begin
                        s.tx_st = TX_STOP1;
                        s.tx_line = 1'b1;
                        brk_done = 1'b1;
                    end
                end
            end
            default: s.tx_st = TX_IDLE;
        endcase
        // break request clears itself, beats a same-cycle write
        if (brk_done) s.brk = 1'b0;

        // Receiver, sampling at mid bit
        s.rx_cnt = (r.rx_st == RX_IDLE || rx_tick) ? '0 : r.rx_cnt + 16'h0001;
        case (r.rx_st)
            RX_IDLE: begin
                if (r.rx_en && !r.rx_s2) s.rx_st = RX_START;
            end
            RX_START: begin
                if (rx_half) begin
                    s.rx_cnt = '0;
                    s.rx_bit = '0;
                    s.rx_st = r.rx_s2 ? RX_IDLE : RX_DATA;
                end
            end
            RX_DATA: begin
                if (rx_tick) begin
                    s.rx_sh = {r.rx_s2, r.rx_sh[7:1]};
                    s.rx_bit = r.rx_bit + 3'h1;
                    if (r.rx_bit == LAST_BIT) s.rx_st = RX_STOP1;
                end
            end
            RX_STOP1: begin
                if (rx_tick) begin
                    framing_error_flag_ev = !r.rx_s2;
                    // select 3 checks only this stop bit
                    if (r.ssel == SSEL_TWO_CHK) begin
                        s.rx_st = RX_STOP2;
                    end else begin
                        s.rx_st = RX_IDLE;
                        push = 1'b1;
                    end
                end
            end
            RX_STOP2: begin
                if (rx_tick) begin
                    framing_error_flag_ev = !r.rx_s2;
                    s.rx_st = RX_IDLE;
                    push = 1'b1;
                end
            end
            default: s.rx_st = RX_IDLE;
        endcase

        // Receive buffer; a character finding it full is dropped
        if (push) begin
            if (r.cnt == DEPTH_CNT) begin
                ovr_ev = 1'b1;
            end else begin
                s.fifo[r.wp] = s.rx_sh;
                s.wp = r.wp + 1'b1;
            end
        end
        if (pop) s.rp = r.rp + 1'b1;
        s.cnt = r.cnt + (PW+1)'(push && !ovr_ev) - (PW+1)'(pop);

        // Sticky flags: a set in the clearing cycle wins
        // overrun holds until written zero
        s.ovr = (r.ovr && !ovr_clr) || ovr_ev;
        s.framing_error_flag = (r.framing_error_flag && !framing_error_flag_clr) || framing_error_flag_ev;
        // write error cleared with the transmitter off
        s.twe = (r.twe && !twe_clr) || twe_ev;

        // Interrupt status clears on read, events still land
        s.ist = (reg_rd && reg_addr == IST_OFS) ? '0 : r.ist;
        s.ist[I_RX] = s.ist[I_RX] || (push && !ovr_ev);
        s.ist[I_OVR] = s.ist[I_OVR] || ovr_ev;
        s.ist[I_FRAMING_ERROR_FLAG] = s.ist[I_FRAMING_ERROR_FLAG] || framing_error_flag_ev;
        s.ist[I_TXD] = s.ist[I_TXD] || (txd_ev && !r.tbuf_full);
        s.irq = |(s.ist & s.mask);
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= ST_RST;
        end else begin
            r <= s;
        end
    end

    // Outputs straight from the state register
    assign reg_rdata = r.rdata;
    assign tx_pin = r.tx_line;
    assign irq = r.irq;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    ovr_set_a: assert property (
        push && r.cnt == DEPTH_CNT |=> r.ovr && r.wp == $past(r.wp))
        else $error("overflow did not set overrun");
    // two stops sent for select 2
    two_stop_tx_a: assert property (
        r.tx_st == TX_STOP1 && tx_tick && r.ssel == SSEL_TWO_CHK
        |=> r.tx_st == TX_STOP2 && tx_pin [*2])
        else $error("second stop bit missing");
    frame_two_a: assert property (
        r.rx_st == RX_STOP2 && rx_tick && !r.rx_s2 |=> r.framing_error_flag)
        else $error("low second stop not flagged");
    // one stop checked for select 3
    one_stop_rx_a: assert property (
        r.rx_st == RX_STOP1 && rx_tick && r.ssel == SSEL_ONE_CHK
        |=> r.rx_st == RX_IDLE)
        else $error("select 3 checked a second stop");
    shifter_empty_a: assert property (
        txd_ev && !r.tbuf_full && !reg_wr |=> sv[S_TX_SHIFTER_EMPTY] && tx_pin)
        else $error("shifter empty not reported");
    buf_empty_a: assert property (
        reg_rd && reg_addr == STAT_OFS
        |=> reg_rdata[S_TBE] == !$past(r.tbuf_full))
        else $error("buffer empty flag wrong");
    brk_clear_a: assert property (
        r.tx_st == TX_BRK && tx_tick && r.tx_bit == BRK_LAST
        |=> !r.brk && r.tx_st == TX_STOP1 && tx_pin)
        else $error("break request not cleared");
    twe_clear_a: assert property (
        reg_wr && reg_addr == MODE_OFS && !reg_wdata[M_TXEN] |=> !r.twe)
        else $error("write error kept after disable");
    ovr_hold_a: assert property (
        r.ovr && !ovr_clr |=> r.ovr)
        else $error("overrun dropped without clear");

endmodule : uss_uart

// *** logic/uss_pkg.sv ***
// Shared offsets, field positions and state types of the serial port block
package uss_pkg;

    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam int ADDR_W = 8;
    localparam logic [7:0] MODE_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] TXD_OFS = 8'h08;
    localparam logic [7:0] RXD_OFS = 8'h0C;
    localparam logic [7:0] BAUD_OFS = 8'h10;
    localparam logic [7:0] IST_OFS = 8'h14;
    localparam logic [7:0] IMSK_OFS = 8'h18;

    // ************************************************************
    // Field positions
    // ************************************************************
    // Mode register
    localparam int M_RXEN = 0;
    localparam int M_TXEN = 1;
    localparam int M_SSEL = 2;
    localparam int M_BRK = 8;
    // Status register
    localparam int S_RXRDY = 0;
    localparam int S_OVR = 1;
    localparam int S_FRAMING_ERROR_FLAG = 2;
    localparam int S_TX_SHIFTER_EMPTY = 3;
    localparam int S_TBE = 4;
    localparam int S_TWE = 7;
    // Interrupt status and mask
    localparam int IRQ_W = 4;
    localparam int I_RX = 0;
    localparam int I_OVR = 1;
    localparam int I_FRAMING_ERROR_FLAG = 2;
    localparam int I_TXD = 3;

    // ************************************************************
    // Codes and counts
    // ************************************************************
    localparam logic [1:0] SSEL_TWO_CHK = 2'h2;
    localparam logic [1:0] SSEL_ONE_CHK = 2'h3;
    localparam logic [15:0] BAUD_RST = 16'h0103;
    localparam logic [3:0] BRK_LAST = 4'hC;
    localparam logic [2:0] LAST_BIT = 3'h7;

    // ************************************************************
    // State types
    // ************************************************************
    typedef enum logic [2:0] {
        TX_IDLE, TX_START, TX_DATA, TX_STOP1, TX_STOP2, TX_BRK
    } uss_tx_type;
    typedef enum logic [2:0] {
        RX_IDLE, RX_START, RX_DATA, RX_STOP1, RX_STOP2
    } uss_rx_type;

endpackage : uss_pkg

// *** bench/uss_remote.sv ***
// Remote serial transceiver facing the serial port block
`timescale 1ns/1ps
module uss_remote #(
    parameter int BIT_CLKS = 5
) (
    // Clock
    input wire logic ref_clk,
    // Serial line
    input wire logic tx_pin,
    output logic rx_pin
);
    int cyc = 0;
    int low_run = 0;
    int last_low = 0;
    int last_start = 0;
    int gap = 0;
    logic [7:0] got_q[$];

    // ************************************************************
    // Line watch
    // ************************************************************
    // Low-run length is kept so a break can be timed exactly
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (!tx_pin) begin
            low_run <= low_run + 1;
        end else if (low_run != 0) begin
            last_low <= low_run;
            low_run <= 0;
        end
    end

    // Receiver samples mid-bit, LSB first; a low stop means break
    initial begin
        logic [7:0] b;
        rx_pin = 1'b1;
        forever begin
            @(negedge tx_pin);
            gap = cyc - last_start;
            last_start = cyc;
            repeat (BIT_CLKS / 2) @(posedge ref_clk);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT_CLKS) @(posedge ref_clk);
                b[i] = tx_pin;
            end
            repeat (BIT_CLKS) @(posedge ref_clk);
            if (tx_pin) begin
                got_q.push_back(b);
            end else begin
                wait (tx_pin);
            end
        end
    end

    // ************************************************************
    // Sender
    // ************************************************************
    // stop count chosen by the caller
    task automatic send(input logic [7:0] b, input int nstop);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 9 + nstop; i++) begin
            @(posedge ref_clk);
            rx_pin <= (i < 10) ? f[i] : 1'b1;
            repeat (BIT_CLKS - 1) @(posedge ref_clk);
        end
    endtask : send
endmodule : uss_remote

// *** bench/uss_uart_tb_top.sv ***
// Self-checking bench for the serial port block
`timescale 1ns/1ps
module uss_uart_tb_top;
    import uss_pkg::*;
    localparam int BIT = 5;
    logic ref_clk;
    logic rst_n;
    logic [ADDR_W-1:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] reg_rdata;
    logic rx_pin;
    logic tx_pin;
    logic irq;
    int n_fail = 0;
    int total_checks = 0;
    logic [31:0] lfsr = 32'h9664A118;
    logic [31:0] d;
    logic [7:0] b0;
    logic [7:0] b1;
    logic [7:0] exp_q[$];

    // ************************************************************
    // Design, far side and clock
    // ************************************************************
    uss_uart #(.RX_DEPTH(8)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_pin(rx_pin),
        .tx_pin(tx_pin), .irq(irq));
    uss_remote #(.BIT_CLKS(BIT)) u_rem (.ref_clk(ref_clk), .tx_pin(tx_pin),
        .rx_pin(rx_pin));
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_reg
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t byte got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_byte
    // Bus cycles change after the edge; read data land one cycle on
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd
    // Bounded poll; a stuck flag shows up in the following compare
    task automatic wait_bit(input logic [7:0] a, input int b, input logic v);
        rd(a);
        for (int i = 0; i < 400 && d[b] !== v; i++) rd(a);
    endtask : wait_bit
    function automatic logic [7:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr[7:0];
    endfunction : rnd
    task automatic do_reset();
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        u_rem.got_q.delete();
        wr(BAUD_OFS, 32'h4);
    endtask : do_reset
    task automatic end_sim();
        $display("checks=%0d fails=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim

    // Watchdog, far beyond the roughly 1500 cycles the tests need
    initial begin
        repeat (30000) @(posedge ref_clk);
        n_fail++;
        end_sim();
    end

    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        rst_n = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        // Reset values and an unmapped place
        rd(MODE_OFS);
        chk_reg(d, 32'h0);
        rd(BAUD_OFS);
        chk_reg(d, {16'h0, BAUD_RST});
        wr(8'h1C, 32'hFFFFFFFF);
        rd(8'h1C);
        chk_reg(d, 32'h0);
        $display("test reset done");
        // Two queued bytes per stop select; start spacing gives stop count
        for (int s = 0; s < 4; s++) begin
            do_reset();
            wr(MODE_OFS, {28'h0, s[1:0], 2'h2});
            b0 = rnd();
            b1 = rnd();
            wr(TXD_OFS, {24'h0, b0});
            wr(TXD_OFS, {24'h0, b1});
            rd(STAT_OFS);
            chk_reg(d & 32'h18, 32'h0);
            wait_bit(STAT_OFS, S_TX_SHIFTER_EMPTY, 1'b1);
            chk_reg(d & 32'h18, 32'h18);
            chk_reg({31'h0, u_rem.cyc - u_rem.last_start >=
                (9 + (s >= 2 ? 2 : 1)) * BIT}, 32'h1);
            chk_reg({31'h0, u_rem.gap >= (9 + (s >= 2 ? 2 : 1)) * BIT &&
                u_rem.gap <= (11 + (s >= 2 ? 2 : 1)) * BIT}, 32'h1);
            // Only the done event may be pending: nothing received here
            rd(IST_OFS);
            chk_reg(d, 32'h8);
            chk_byte(u_rem.got_q.pop_front(), b0);
            chk_byte(u_rem.got_q.pop_front(), b1);
        end
        $display("test tx stop bits done");
        // One stop bit back to back: select 2 flags it, select 3 not
        for (int s = 2; s < 4; s++) begin
            do_reset();
            wr(MODE_OFS, {28'h0, s[1:0], 2'h1});
            b0 = rnd();
            b1 = rnd();
            u_rem.send(b0, 1);
            u_rem.send(b1, 1);
            repeat (12 * BIT) @(posedge ref_clk);
            rd(STAT_OFS);
            chk_reg({31'h0, d[S_FRAMING_ERROR_FLAG]}, {31'h0, s == 2});
            wr(STAT_OFS, 32'h0);
            rd(STAT_OFS);
            chk_reg(d & 32'h6, 32'h0);
            rd(RXD_OFS);
            chk_reg(d, {24'h0, b0});
            if (s == 3) begin
                rd(RXD_OFS);
                chk_reg(d, {24'h0, b1});
            end
        end
        $display("test rx stop check done");
        // Nine bytes unread: overrun, interrupt, ninth byte lost
        do_reset();
        wr(MODE_OFS, 32'h1);
        for (int i = 0; i < 9; i++) begin
            b0 = rnd();
            exp_q.push_back(b0);
            u_rem.send(b0, 1);
        end
        repeat (2 * BIT) @(posedge ref_clk);
        rd(STAT_OFS);
        chk_reg(d & 32'h2, 32'h2);
        chk_reg({31'h0, irq}, 32'h0);
        wr(IMSK_OFS, 32'h2);
        repeat (2) @(posedge ref_clk);
        chk_reg({31'h0, irq}, 32'h1);
        rd(IST_OFS);
        chk_reg(d & 32'h2, 32'h2);
        repeat (2) @(posedge ref_clk);
        chk_reg({31'h0, irq}, 32'h0);
        for (int i = 0; i < 8; i++) begin
            rd(RXD_OFS);
            chk_reg(d, {24'h0, exp_q.pop_front()});
        end
        wr(STAT_OFS, 32'h2);
        rd(STAT_OFS);
        chk_reg(d & 32'h2, 32'h2);
        wr(STAT_OFS, 32'h0);
        rd(STAT_OFS);
        chk_reg(d & 32'h2, 32'h0);
        $display("test overrun done");
        // Break: thirteen bit times low, request bit clears itself
        do_reset();
        wr(MODE_OFS, 32'h102);
        rd(MODE_OFS);
        chk_reg(d, 32'h102);
        wait_bit(MODE_OFS, M_BRK, 1'b0);
        repeat (4 * BIT) @(posedge ref_clk);
        chk_reg(d, 32'h2);
        chk_reg(32'(u_rem.last_low), 32'(13 * BIT));
        $display("test break done");
        // Third byte overfills: write error, cleared by disabling
        do_reset();
        wr(MODE_OFS, 32'h2);
        for (int i = 0; i < 3; i++) wr(TXD_OFS, {24'h0, rnd()});
        rd(STAT_OFS);
        chk_reg(d & 32'h80, 32'h80);
        wr(MODE_OFS, 32'h0);
        rd(STAT_OFS);
        chk_reg(d & 32'h80, 32'h0);
        $display("test write error done");
        end_sim();
    end
endmodule : uss_uart_tb_top
